// [design/efs_map.vh]
`ifndef EFS_MAP_VH
`define EFS_MAP_VH

// Register word offsets on the host register port
`define EFS_ADDR_W            12
`define EFS_DATA_W            16
`define EFS_OFF_FLAGS_RX      12'h004
`define EFS_OFF_FLAGS_OUT     12'h005
`define EFS_OFF_STREAM1       12'h006
`define EFS_OFF_STREAM2       12'h007

// Received flag register fields
`define EFS_RX_ERR_HERE_BIT   0
`define EFS_RX_ERR_ALR_BIT    1
`define EFS_RX_IERR_HERE_BIT  2
`define EFS_RX_FOUND_BIT      15

// Outgoing flag register: three five-bit groups, bit 15 reserved
`define EFS_GRP_W             5
`define EFS_GRP_PICTURE_LSB   0
`define EFS_GRP_FIELD_LSB     5
`define EFS_GRP_AUX_LSB       10
`define EFS_GRP_UNKNOWN_BIT   4
`define EFS_GRP_RESET         5'h10

// Stream format register fields
`define EFS_FIELD_CRC_BIT     15
`define EFS_PICT_CRC_BIT      14
`define EFS_STD_MSB           13
`define EFS_STD_LSB           8
`define EFS_CHROMA_MSB        7
`define EFS_CHROMA_LSB        4
`define EFS_LUMA_MSB          3
`define EFS_LUMA_LSB          0
`define EFS_STD_RESET         6'h1d
`define EFS_FMT_RESET         4'hf

`endif

// [design/efs_status_regs.v]
`timescale 1ns/10ps
`include "efs_map.vh"

// Summary of operation
// - Received picture flags: error here bit 0, already bit 1, internal here bit 2.
// - Outgoing flags: aux 14-10, field 9-5, picture 4-0; bit 15 reserved.
// - Group order unknown, internal already, internal here, already, here; unknown resets 1.
// - Full-field CRC validity at stream-1 bit 15, clear after reset.
// - Active-picture CRC validity at stream-1 bit 14, clear after reset.
// - Stream-1 detected standard at bits 13-8, resets to 29.
// - Stream-1 bits 7-4: chroma code, or stream-2 code for level A; reset 15.
// - Stream-1 bits 3-0: luma code, or stream-1 code for level A; reset 15.
// - Level B only: stream-2 standard at bits 13-8, reset 29; bits 15-14 zero.
// - Level B only: stream-2 chroma at 7-4, luma at 3-0, both reset 15.
// - Bit 15 of received flags sets when an embedded check packet is found.
module efs_status_regs (
  // Clock and reset
  input  wire                    clk_in,
  input  wire                    rst_b_in,
  // Host register port
  input  wire [`EFS_ADDR_W-1:0]  reg_addr_in,
  input  wire                    reg_rd_in,
  input  wire                    reg_wr_in,
  input  wire [`EFS_DATA_W-1:0]  reg_wdata_in,
  output reg  [`EFS_DATA_W-1:0]  reg_rdata_out,
  output reg                     reg_rvalid_out,
  // Received check packet from the stream decoder
  input  wire                    rx_packet_in,
  input  wire                    rx_packet_lost_in,
  input  wire                    rx_picture_err_here_in,
  input  wire                    rx_picture_err_already_in,
  input  wire                    rx_picture_internal_err_here_in,
  input  wire                    field_crc_valid_in,
  input  wire                    picture_crc_valid_in,
  // Outgoing flags from the local checker
  input  wire                    out_flags_load_in,
  input  wire [14:0]             out_flags_in,
  // Format detection results
  input  wire                    fmt_load_in,
  input  wire                    level_a_in,
  input  wire                    level_b_in,
  input  wire [5:0]              stream1_standard_in,
  input  wire [5:0]              stream2_standard_in,
  input  wire [3:0]              chroma_code_in,
  input  wire [3:0]              luma_code_in,
  input  wire [3:0]              stream1_code_in,
  input  wire [3:0]              stream2_code_in,
  input  wire [3:0]              stream2_chroma_code_in,
  input  wire [3:0]              stream2_luma_code_in
);

  // Received flag state
  reg                            check_packet_found_q;
  reg                            check_packet_found_d;
  reg                            rx_picture_err_here_q;
  reg                            rx_picture_err_already_q;
  reg                            rx_picture_internal_err_here_q;
  reg                            field_crc_valid_q;
  reg                            picture_crc_valid_q;
  // Outgoing flag groups
  wire [14:0]                    out_flags_q;
  // Stream format state
  reg  [5:0]                     stream1_standard_q;
  reg  [3:0]                     stream1_chroma_format_q;
  reg  [3:0]                     stream1_luma_format_q;
  reg  [5:0]                     stream2_standard_q;
  reg  [3:0]                     stream2_chroma_format_q;
  reg  [3:0]                     stream2_luma_format_q;
  // Read path
  reg  [`EFS_DATA_W-1:0]         reg_rdata_d;
  wire [`EFS_DATA_W-1:0]         flags_rx_word;
  wire [`EFS_DATA_W-1:0]         flags_out_word;
  wire [`EFS_DATA_W-1:0]         stream1_word;
  wire [`EFS_DATA_W-1:0]         stream2_word;
  wire                           unused_write;

  function is_mapped;
    input [`EFS_ADDR_W-1:0] addr;
    begin
      is_mapped = (addr == `EFS_OFF_FLAGS_RX) || (addr == `EFS_OFF_FLAGS_OUT) ||
                  (addr == `EFS_OFF_STREAM1) || (addr == `EFS_OFF_STREAM2);
    end
  endfunction

  // Writes reach no storage here; the register set is read-only
  assign unused_write = reg_wr_in & (|reg_wdata_in) & is_mapped(reg_addr_in);

  // Packet found flag: a new packet in the same cycle as a loss keeps the flag set
  always @* begin
    check_packet_found_d = check_packet_found_q;
    if (rx_packet_lost_in) begin
      check_packet_found_d = 1'b0;
    end
    if (rx_packet_in) begin
      check_packet_found_d = 1'b1;
    end
  end

  always @(posedge clk_in) begin
    if (!rst_b_in) begin
      check_packet_found_q           <= 1'b0;
      rx_picture_err_here_q          <= 1'b0;
      rx_picture_err_already_q       <= 1'b0;
      rx_picture_internal_err_here_q <= 1'b0;
      field_crc_valid_q              <= 1'b0;
      picture_crc_valid_q            <= 1'b0;
    end else begin
      check_packet_found_q <= check_packet_found_d;
      if (rx_packet_in) begin
        rx_picture_err_here_q          <= rx_picture_err_here_in;
        rx_picture_err_already_q       <= rx_picture_err_already_in;
        rx_picture_internal_err_here_q <= rx_picture_internal_err_here_in;
        field_crc_valid_q              <= field_crc_valid_in;
        picture_crc_valid_q            <= picture_crc_valid_in;
      end
    end
  end

  // One register per outgoing group; only the unknown-status bit resets high
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_out_grp
      reg [`EFS_GRP_W-1:0] grp_q;
      always @(posedge clk_in) begin
        if (!rst_b_in) begin
          grp_q <= `EFS_GRP_RESET;
        end else if (out_flags_load_in) begin
          grp_q <= out_flags_in[g*`EFS_GRP_W +: `EFS_GRP_W];
        end
      end
      assign out_flags_q[g*`EFS_GRP_W +: `EFS_GRP_W] = grp_q;
    end
  endgenerate

  always @(posedge clk_in) begin
    if (!rst_b_in) begin
      stream1_standard_q      <= `EFS_STD_RESET;
      stream1_chroma_format_q <= `EFS_FMT_RESET;
      stream1_luma_format_q   <= `EFS_FMT_RESET;
      stream2_standard_q      <= `EFS_STD_RESET;
      stream2_chroma_format_q <= `EFS_FMT_RESET;
      stream2_luma_format_q   <= `EFS_FMT_RESET;
    end else if (fmt_load_in) begin
      stream1_standard_q <= stream1_standard_in;
      if (level_a_in) begin
        stream1_chroma_format_q <= stream2_code_in;
        stream1_luma_format_q   <= stream1_code_in;
      end else begin
        stream1_chroma_format_q <= chroma_code_in;
        stream1_luma_format_q   <= luma_code_in;
      end
      // Stream 2 holds its last value outside level B
      if (level_b_in) begin
        stream2_standard_q      <= stream2_standard_in;
        stream2_chroma_format_q <= stream2_chroma_code_in;
        stream2_luma_format_q   <= stream2_luma_code_in;
      end
    end
  end

  assign flags_rx_word = {check_packet_found_q, 12'h000,
                          rx_picture_internal_err_here_q,
                          rx_picture_err_already_q,
                          rx_picture_err_here_q};
  assign flags_out_word = {1'b0, out_flags_q};
  assign stream1_word = {field_crc_valid_q, picture_crc_valid_q, stream1_standard_q,
                         stream1_chroma_format_q, stream1_luma_format_q};
  assign stream2_word = {2'b00, stream2_standard_q,
                         stream2_chroma_format_q, stream2_luma_format_q};

  // Read mux; unmapped addresses return zero
  always @* begin
    case (reg_addr_in)
      `EFS_OFF_FLAGS_RX:  reg_rdata_d = flags_rx_word;
      `EFS_OFF_FLAGS_OUT: reg_rdata_d = flags_out_word;
      `EFS_OFF_STREAM1:   reg_rdata_d = stream1_word;
      `EFS_OFF_STREAM2:   reg_rdata_d = stream2_word;
      default:            reg_rdata_d = 16'h0000;
    endcase
  end

  // Reading only samples the mux; no state depends on a read
  always @(posedge clk_in) begin
    if (!rst_b_in) begin
      reg_rdata_out  <= 16'h0000;
      reg_rvalid_out <= 1'b0;
    end else begin
      reg_rvalid_out <= reg_rd_in;
      if (reg_rd_in) begin
        reg_rdata_out <= reg_rdata_d;
      end
    end
  end

endmodule // efs_status_regs

// [bench/efs_status_regs_props.sv]
`timescale 1ns/10ps
module efs_status_props (
  // Clock, reset and host port
  input logic        clk_in,
  input logic        rst_b_in,
  input logic [11:0] reg_addr_in,
  input logic        reg_rd_in,
  input logic [15:0] reg_rdata_out,
  input logic        reg_rvalid_out,
  // Status sources
  input logic        rx_packet_in,
  input logic        rx_picture_err_here_in,
  input logic        rx_picture_err_already_in,
  input logic        rx_picture_internal_err_here_in,
  input logic        field_crc_valid_in,
  input logic        picture_crc_valid_in,
  input logic        out_flags_load_in,
  input logic [14:0] out_flags_in,
  input logic        fmt_load_in,
  input logic        level_a_in,
  input logic [3:0]  stream1_code_in,
  input logic [3:0]  stream2_code_in
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  wire rd4 = reg_rd_in && reg_addr_in == 12'h004;
  wire rd5 = reg_rd_in && reg_addr_in == 12'h005;
  wire rd6 = reg_rd_in && reg_addr_in == 12'h006;
  wire rd7 = reg_rd_in && reg_addr_in == 12'h007;
  a_read_answered: assert property (reg_rd_in |=> reg_rvalid_out)
    else $error("read not answered");
  a_quiet_hold: assert property (!reg_rd_in |=> !reg_rvalid_out && $stable(reg_rdata_out))
    else $error("port moved without a read");
  a_rx_flags_load: assert property (rx_packet_in ##1 rd4 |=> reg_rdata_out[15] &&
    reg_rdata_out[2:0] == {$past(rx_picture_internal_err_here_in, 2),
    $past(rx_picture_err_already_in, 2), $past(rx_picture_err_here_in, 2)})
    else $error("received flags wrong");
  a_crc_valid_load: assert property (rx_packet_in ##1 rd6 |=>
    reg_rdata_out[15:14] == {$past(field_crc_valid_in, 2), $past(picture_crc_valid_in, 2)})
    else $error("crc validity wrong");
  a_out_flags_load: assert property (out_flags_load_in ##1 rd5 |=>
    reg_rdata_out == {1'b0, $past(out_flags_in, 2)}) else $error("outgoing flags wrong");
  a_level_a_codes: assert property (fmt_load_in && level_a_in ##1 rd6 |=>
    reg_rdata_out[7:0] == {$past(stream2_code_in, 2), $past(stream1_code_in, 2)})
    else $error("level A codes wrong");
  a_out_top_zero: assert property (rd5 |=> !reg_rdata_out[15])
    else $error("outgoing bit 15 set");
  a_stream2_top_zero: assert property (rd7 |=> reg_rdata_out[15:14] == 2'b00)
    else $error("stream 2 top bits set");
  a_unmapped_zero: assert property (reg_rd_in && (reg_addr_in < 12'h004 ||
    reg_addr_in > 12'h007) |=> reg_rdata_out == 16'h0000) else $error("unmapped read not zero");
endmodule // efs_status_props
bind efs_status_regs efs_status_props u_props (.clk_in, .rst_b_in, .reg_addr_in, .reg_rd_in,
  .reg_rdata_out, .reg_rvalid_out, .rx_packet_in, .rx_picture_err_here_in,
  .rx_picture_err_already_in, .rx_picture_internal_err_here_in, .field_crc_valid_in,
  .picture_crc_valid_in, .out_flags_load_in, .out_flags_in, .fmt_load_in, .level_a_in,
  .stream1_code_in, .stream2_code_in);

// [bench/efs_status_regs_bench.sv]
`timescale 1ns/10ps
module efs_status_regs_bench;
  logic        clk_in = 1'b0, rst_b_in = 1'b0, reg_rd_in = 1'b0, reg_wr_in = 1'b0;
  logic [11:0] reg_addr_in = 12'h000;
  logic [15:0] reg_wdata_in = 16'h0000;
  wire  [15:0] reg_rdata_out;
  wire         reg_rvalid_out;
  // Strobes: fmt, out, lost, packet; flags: internal here, already, here
  logic [3:0]  stb = 4'h0, cc = 4'h0, lc = 4'h0, s1c = 4'h0, s2c = 4'h0, s2cc = 4'h0, s2lc = 4'h0;
  logic [2:0]  rxf = 3'h0;
  logic [1:0]  crc = 2'h0, lvl = 2'h0;
  logic [14:0] oflg = 15'h0000;
  logic [5:0]  std1 = 6'h00, std2 = 6'h00;
  int          mismatches = 0, check_count = 0;
  efs_status_regs u_dut (.clk_in(clk_in), .rst_b_in(rst_b_in), .reg_addr_in(reg_addr_in),
    .reg_rd_in(reg_rd_in), .reg_wr_in(reg_wr_in), .reg_wdata_in(reg_wdata_in),
    .reg_rdata_out(reg_rdata_out), .reg_rvalid_out(reg_rvalid_out), .rx_packet_in(stb[0]),
    .rx_packet_lost_in(stb[1]), .rx_picture_err_here_in(rxf[0]),
    .rx_picture_err_already_in(rxf[1]), .rx_picture_internal_err_here_in(rxf[2]),
    .field_crc_valid_in(crc[1]), .picture_crc_valid_in(crc[0]), .out_flags_load_in(stb[2]),
    .out_flags_in(oflg), .fmt_load_in(stb[3]), .level_a_in(lvl[0]), .level_b_in(lvl[1]),
    .stream1_standard_in(std1), .stream2_standard_in(std2), .chroma_code_in(cc),
    .luma_code_in(lc), .stream1_code_in(s1c), .stream2_code_in(s2c),
    .stream2_chroma_code_in(s2cc), .stream2_luma_code_in(s2lc));
  initial forever #50 clk_in = ~clk_in;
  task automatic tick;
    @(posedge clk_in);
    #1;
  endtask
  task automatic close_out;
    $display("mismatches %0d check_count %0d", mismatches, check_count);
    if (mismatches == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic fire(input logic [3:0] m);
    tick;
    reg_rd_in = 1'b0;
    stb = m;
    tick;
    stb = 4'h0;
  endtask
  // Valid must show on the edge after the request, so there is nothing to wait for.
  // The read strobe stays up between reads so that back-to-back reads follow a load directly.
  task automatic rd(input logic [11:0] a, input logic [15:0] exp);
    reg_addr_in = a;
    reg_rd_in = 1'b1;
    tick;
    check_count++;
    if (reg_rvalid_out !== 1'b1 || reg_rdata_out !== exp) begin
      mismatches++;
      $display("BAD %0t: addr %h got %h want %h", $time, a, reg_rdata_out, exp);
    end
  endtask
  initial begin
    repeat (20) @(posedge clk_in);
    #1;
    rst_b_in = 1'b1;
    for (int a = 3; a < 9; a++) begin
      tick;
      reg_addr_in = a[11:0];
      reg_wdata_in = 16'hffff;
      reg_wr_in = 1'b1;
    end
    tick;
    reg_wr_in = 1'b0;
    rd(12'h003, 16'h0000);
    rd(12'h004, 16'h0000);
    rd(12'h005, 16'h4210);
    rd(12'h006, 16'h1dff);
    rd(12'h007, 16'h1dff);
    rd(12'h008, 16'h0000);
    rxf = 3'h5;
    crc = 2'h2;
    fire(4'h1);
    rd(12'h006, 16'h9dff);
    rd(12'h004, 16'h8005);
    fire(4'h2);
    rd(12'h004, 16'h0005);
    rxf = 3'h2;
    crc = 2'h1;
    fire(4'h3);
    rd(12'h004, 16'h8002);
    oflg = 15'h5a5a;
    fire(4'h4);
    rd(12'h005, 16'h5a5a);
    {lvl, std1, std2, cc, lc, s2cc, s2lc, s1c, s2c} = {2'h2, 6'h2a, 6'h15, 24'h3c_695a};
    fire(4'h8);
    rd(12'h006, 16'h6a3c);
    rd(12'h007, 16'h1569);
    {lvl, std1, std2} = {2'h1, 6'h01, 6'h3f};
    fire(4'h8);
    rd(12'h006, 16'h41a5);
    rd(12'h007, 16'h1569);
    tick;
    reg_rd_in = 1'b0;
    tick;
    close_out;
  end
endmodule // efs_status_regs_bench
